// *** verilog/insc_ctrl.sv ***
// interrupt nesting control with standby entry and wake logic
//
// Notes on behaviour
// - high-order source accepted in status 0 or 1
// - status 00 to 01 to 10, 10 accepts none
// - both status bits set accepts nothing
// - acceptance pushes status, then advances one level
// - return restores status pushed at acceptance
// - status written to 00 allows any nesting
// - single enabled shared source cleared on acceptance
// - both shared sources enabled form one request
// - both shared enabled, no flag cleared on acceptance
// - stop sets control bit 3, halt bit 2
// - stop only on main clock, halt on either
// - stop halts main clock, halt only cpu clock
// - interval timer stops in stop, runs in halt
// - serial channels run per clock source and mode
// - counter on pin, watch on subclock in stop
// - pulse gen, event counter, converter stop in stop
// - first external input inactive in standby
// - standby keeps all register contents
// - enabled pending request other than the first input, or reset, ends standby
// - pending at entry releases at once, stop waits
// - low three bits pick high-order, bit 3 enables
// - status flags are word bits 3 and 2
// - wake with enable runs two instructions, then vectors
`include "insc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module insc_ctrl #(
  parameter int WAIT20 = `INSC_WAIT20, // longest wake wait
  parameter int WAIT17 = `INSC_WAIT17, // wake wait option
  parameter int WAIT15 = `INSC_WAIT15, // wake wait option
  parameter int WAIT13 = `INSC_WAIT13  // shortest wake wait
) (
  input wire logic mclk, // system clock, 25 MHz
  input wire logic srst, // synchronous reset, high
  input wire logic [3:0] regAddr, // register index
  input wire logic [15:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [15:0] regRdata, // read data, next cycle
  input wire insc_pkg::insc_cpu_t cpu, // instruction strobes
  input wire logic [1:0] restoreNest, // status popped by return
  input wire logic [3:0] extPin, // external inputs d,c,b,a
  input wire logic btTick, // interval timer reference tick
  input wire logic [4:0] unitEvent, // serial,timer,pulse,keyscan,watch
  input wire insc_pkg::insc_sel_t clkSel, // unit clock choices
  output logic vecReq, // vector request to cpu
  output logic [2:0] vecIdx, // vector number
  output logic [1:0] pushNest, // status pushed at acceptance
  output logic resumeCpu, // one-cycle pulse on wake
  output insc_pkg::insc_run_t unitRun, // unit run enables
  output insc_pkg::insc_sb_t sbState // standby state
);
  import insc_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [3:0] prio; // priority select register
  logic [1:0] nest; // nesting status hi,lo
  logic [9:0] irq; // request flags
  logic [9:0] ien; // source enable flags
  logic [3:0] processor_clock_control; // processor clock control
  logic [3:0] interval_timer_mode_register; // interval timer mode register
  logic [20:0] waitCnt; // wake wait down counter
  logic [1:0] holdCnt; // instructions left before vectoring
  logic [3:0] pinS1, pinS2, pinOld; // pin synchronisers
  insc_sb_t next_sbState; // next standby state
  logic master_irq_enable; // master enable
  assign master_irq_enable = prio[`INSC_PRIO_IME];

  // ----------------------------------------
  // run enables per standby state
  // ----------------------------------------
  logic isStop, isStby; // mode decodes
  insc_run_t next_unitRun; // enables from state
  assign isStop = (sbState == SB_STOP);
  assign isStby = (sbState != SB_RUN);
  // the wait after stop runs the oscillator, so it behaves as halt
  always_comb begin
    next_unitRun.mainClk = !isStop;
    next_unitRun.cpuClk = !isStby;
    next_unitRun.bt = !isStop;
    if (isStop) begin
      next_unitRun.ser0 = clkSel.ser0Ext;
      next_unitRun.ser1 = clkSel.ser1Ext;
      next_unitRun.tmr0 = clkSel.tmr0Pin;
      next_unitRun.watch = clkSel.watchSub;
      next_unitRun.tpg = 1'b0;
      next_unitRun.evc = 1'b0;
      next_unitRun.adc = 1'b0;
    end else if (isStby) begin
      next_unitRun.ser0 = clkSel.mainOscOn | clkSel.ser0Ext;
      next_unitRun.ser1 = clkSel.mainOscOn;
      next_unitRun.tmr0 = 1'b1;
      next_unitRun.watch = 1'b1;
      next_unitRun.tpg = clkSel.mainOscOn;
      next_unitRun.evc = clkSel.mainOscOn;
      next_unitRun.adc = clkSel.mainOscOn;
    end else begin
      next_unitRun.ser0 = 1'b1;
      next_unitRun.ser1 = 1'b1;
      next_unitRun.tmr0 = 1'b1;
      next_unitRun.watch = 1'b1;
      next_unitRun.tpg = 1'b1;
      next_unitRun.evc = 1'b1;
      next_unitRun.adc = 1'b1;
    end
  end

  // register the enables so the units see clean levels
  always_ff @(posedge mclk) begin
    if (srst) begin
      unitRun <= '1;
    end else begin
      unitRun <= next_unitRun;
    end
  end

  // ----------------------------------------
  // external pins and request events
  // ----------------------------------------
  // two flops before anything looks at a pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinS1 <= `INSC_RST_4;
      pinS2 <= `INSC_RST_4;
      pinOld <= `INSC_RST_4;
    end else begin
      pinS1 <= extPin;
      pinS2 <= pinS1;
      pinOld <= pinS2;
    end
  end

  logic [3:0] pinRise; // rising edges d,c,b,a
  logic [9:0] setEv; // hardware set pulses
  assign pinRise = pinS2 & ~pinOld;
  always_comb begin
    setEv = `INSC_RST_10;
    setEv[`INSC_SRC_BT] = btTick & next_unitRun.bt;
    setEv[`INSC_SRC_D] = pinRise[3];
    // first input is sampled by the cpu clock, dead in standby
    setEv[`INSC_SRC_A] = pinRise[0] & !isStby;
    setEv[`INSC_SRC_B] = pinRise[1];
    setEv[`INSC_SRC_C] = pinRise[2];
    setEv[8:4] = unitEvent;
  end

  // ----------------------------------------
  // vector requests and selection
  // ----------------------------------------
  // vectors: 0 shared, 1 a, 2 b, 3..7 serial..watch
  logic [7:0] vReq; // per-vector request
  logic bothShared; // both shared sources enabled
  logic [9:0] pend; // pending and enabled
  assign pend = irq & ien;
  assign bothShared = ien[`INSC_SRC_BT] & ien[`INSC_SRC_D];
  // either flag raises the shared request when both are enabled
  assign vReq[0] = pend[`INSC_SRC_BT] | pend[`INSC_SRC_D];
  assign vReq[1] = pend[`INSC_SRC_A];
  assign vReq[2] = pend[`INSC_SRC_B];
  assign vReq[7:3] = pend[8:4];

  logic [7:0] okReq; // acceptable now
  logic [2:0] pick; // chosen vector
  logic anyOk; // something acceptable
  always_comb begin
    okReq = 8'h00;
    pick = 3'h0;
    anyOk = 1'b0;
    if (master_irq_enable && holdCnt == 2'h0) begin
      case (nest)
        2'b00: okReq = vReq;
        2'b01: okReq = vReq & (8'h01 << prio[2:0]);
        default: okReq = 8'h00;
      endcase
    end
    // high-order first, then lowest vector number
    if (okReq[prio[2:0]]) begin
      pick = prio[2:0];
      anyOk = 1'b1;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        if (okReq[i]) begin
          pick = 3'(i);
          anyOk = 1'b1;
        end
      end
    end
  end

  // request and index stand until the cpu takes them
  always_ff @(posedge mclk) begin
    if (srst) begin
      vecReq <= 1'b0;
      vecIdx <= 3'h0;
    end else begin
      vecReq <= anyOk && !(cpu.take && vecReq) && sbState == SB_RUN;
      vecIdx <= pick;
    end
  end
  logic taken; // acceptance this cycle
  assign taken = cpu.take & vecReq;

  // ----------------------------------------
  // nesting status
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      nest <= 2'b00;
      pushNest <= 2'b00;
    end else if (taken) begin
      pushNest <= nest;
      nest <= (nest == 2'b00) ? 2'b01 : 2'b10;
    end else if (cpu.return_from_interrupt) begin
      nest <= restoreNest;
    end else if (regWr && regAddr == `INSC_OFS_PSW) begin
      // writing 00 reopens every source
      nest <= regWdata[`INSC_PSW_NHI:`INSC_PSW_NLO];
    end
  end

  // ----------------------------------------
  // request flags
  // ----------------------------------------
  logic [9:0] takeClr; // flags cleared by acceptance
  always_comb begin
    takeClr = `INSC_RST_10;
    if (taken) begin
      case (vecIdx)
        3'h0: begin
          // a lone enabled shared source clears, a pair clears none
          if (!bothShared) begin
            takeClr[`INSC_SRC_BT] = ien[`INSC_SRC_BT];
            takeClr[`INSC_SRC_D] = ien[`INSC_SRC_D];
          end
        end
        3'h1: takeClr[`INSC_SRC_A] = 1'b1;
        3'h2: takeClr[`INSC_SRC_B] = 1'b1;
        // widen first so vector 7 reaches flag 8 and does not wrap to flag 0
        default: takeClr[4'(vecIdx) + 4'h1] = 1'b1;
      endcase
    end
  end

  // hardware set wins over any clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= `INSC_RST_10;
    end else if (regWr && regAddr == `INSC_OFS_IRQ) begin
      irq <= regWdata[9:0] | setEv;
    end else begin
      irq <= (irq & ~takeClr) | setEv;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // only srst, a write, or ei/di on the enable bit alter these, so standby keeps them
  always_ff @(posedge mclk) begin
    if (srst) begin
      prio <= `INSC_RST_4;
      ien <= `INSC_RST_10;
      interval_timer_mode_register <= `INSC_RST_4;
    end else begin
      if (regWr && regAddr == `INSC_OFS_PRIO) begin
        prio <= regWdata[3:0];
      end else if (cpu.ei) begin
        prio[`INSC_PRIO_IME] <= 1'b1;
      end else if (cpu.di) begin
        prio[`INSC_PRIO_IME] <= 1'b0;
      end
      if (regWr && regAddr == `INSC_OFS_IEN) begin
        ien <= regWdata[9:0];
      end
      if (regWr && regAddr == `INSC_OFS_BTM) begin
        interval_timer_mode_register <= regWdata[3:0];
      end
    end
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        `INSC_OFS_PRIO: regRdata <= {12'h000, prio};
        `INSC_OFS_PSW: regRdata <= {12'h000, nest, 2'b00};
        `INSC_OFS_IRQ: regRdata <= {6'h00, irq};
        `INSC_OFS_IEN: regRdata <= {6'h00, ien};
        `INSC_OFS_PCC: regRdata <= {12'h000, processor_clock_control};
        `INSC_OFS_BTM: regRdata <= {12'h000, interval_timer_mode_register};
        `INSC_OFS_STAT: regRdata <= {12'h000, holdCnt, sbState};
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // standby control
  // ----------------------------------------
  logic wake; // enabled request present
  logic [20:0] waitLoad; // wait chosen by the mode register
  // the first input cannot wake, it is dead in standby
  assign wake = |(pend & ~(10'h001 << `INSC_SRC_A));
  always_comb begin
    case (interval_timer_mode_register[2:0])
      3'b011: waitLoad = 21'(WAIT17);
      3'b101: waitLoad = 21'(WAIT15);
      3'b111: waitLoad = 21'(WAIT13);
      default: waitLoad = 21'(WAIT20 - 1);
    endcase
  end

  always_comb begin
    next_sbState = sbState;
    case (sbState)
      SB_RUN: begin
        // stop only from the main clock; a pending wake skips ahead
        if (cpu.stop && !clkSel.cpuOnSub) begin
          next_sbState = wake ? SB_WAIT : SB_STOP;
        end else if (cpu.halt && !wake) begin
          next_sbState = SB_HALT;
        end
      end
      SB_HALT: if (wake) next_sbState = SB_RUN;
      SB_STOP: if (wake) next_sbState = SB_WAIT;
      SB_WAIT: if (waitCnt == 21'h0) next_sbState = SB_RUN;
      default: next_sbState = SB_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sbState <= SB_RUN;
    end else begin
      sbState <= next_sbState;
    end
  end

  // wait counter loads as the wait state opens
  always_ff @(posedge mclk) begin
    if (srst) begin
      waitCnt <= 21'h0;
    end else if (next_sbState == SB_WAIT && sbState != SB_WAIT) begin
      waitCnt <= waitLoad;
    end else if (waitCnt != 21'h0) begin
      waitCnt <= waitCnt - 21'h1;
    end
  end

  // mode bits follow the state and clear on release
  always_ff @(posedge mclk) begin
    if (srst) begin
      processor_clock_control <= `INSC_RST_4;
    end else begin
      if (regWr && regAddr == `INSC_OFS_PCC) begin
        processor_clock_control[1:0] <= regWdata[1:0];
      end
      processor_clock_control[`INSC_PCC_STOP] <= (next_sbState == SB_STOP) || (next_sbState == SB_WAIT);
      processor_clock_control[`INSC_PCC_HALT] <= (next_sbState == SB_HALT);
    end
  end

  // wake: resume, and with enable let two instructions pass
  always_ff @(posedge mclk) begin
    if (srst) begin
      resumeCpu <= 1'b0;
      holdCnt <= 2'h0;
    end else begin
      resumeCpu <= isStby && next_sbState == SB_RUN;
      if (isStby && next_sbState == SB_RUN && master_irq_enable) begin
        holdCnt <= `INSC_WAKE_INSTR;
      end else if (cpu.instrDone && holdCnt != 2'h0) begin
        holdCnt <= holdCnt - 2'h1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_take_advances: assert property (@(posedge mclk) disable iff (srst)
    taken && nest == 2'b00 |=> nest == 2'b01 && pushNest == 2'b00)
    else $error("status did not advance from 0");
  a_high_only: assert property (@(posedge mclk) disable iff (srst)
    vecReq && $past(nest) == 2'b01 |-> vecIdx == $past(prio[2:0]))
    else $error("low-order vector in status 1");
  a_status2_none: assert property (@(posedge mclk) disable iff (srst)
    nest[1] && !taken |=> !vecReq)
    else $error("request offered in status 2 or 3");
  a_return_from_interrupt_restore: assert property (@(posedge mclk) disable iff (srst)
    cpu.return_from_interrupt && !taken |=> nest == $past(restoreNest))
    else $error("return did not restore status");
  a_shared_keep: assert property (@(posedge mclk) disable iff (srst)
    taken && vecIdx == 3'h0 && bothShared |=> irq[1:0] == $past(irq[1:0]))
    else $error("shared flag cleared with both enabled");
  a_stop_clocks: assert property (@(posedge mclk) disable iff (srst)
    sbState == SB_STOP |=> !unitRun.mainClk && !unitRun.cpuClk && !unitRun.tpg)
    else $error("unit running in stop");
  a_halt_wake: assert property (@(posedge mclk) disable iff (srst)
    sbState == SB_HALT && wake |=> sbState == SB_RUN && resumeCpu)
    else $error("halt not released");
  a_stop_wait: assert property (@(posedge mclk) disable iff (srst)
    sbState == SB_STOP && wake |=> sbState == SB_WAIT ##1 processor_clock_control[`INSC_PCC_STOP])
    else $error("stop release skipped wait");
  a_wake_hold: assert property (@(posedge mclk) disable iff (srst)
    resumeCpu && master_irq_enable |-> holdCnt == `INSC_WAKE_INSTR && !vecReq)
    else $error("vectored before two instructions");
endmodule
`default_nettype wire

// *** verilog/insc_defs.svh ***
// offsets, field positions, reset values and timing counts of the nesting/standby controller
`ifndef INSC_DEFS_SVH
`define INSC_DEFS_SVH
// register offsets (word index on the plain port)
`define INSC_OFS_PRIO 4'h0
`define INSC_OFS_PSW 4'h1
`define INSC_OFS_IRQ 4'h2
`define INSC_OFS_IEN 4'h3
`define INSC_OFS_PCC 4'h4
`define INSC_OFS_BTM 4'h5
`define INSC_OFS_STAT 4'h6
// field positions
`define INSC_PRIO_IME 3
`define INSC_PSW_NHI 3
`define INSC_PSW_NLO 2
`define INSC_PCC_STOP 3
`define INSC_PCC_HALT 2
// request flag positions
`define INSC_SRC_BT 0
`define INSC_SRC_D 1
`define INSC_SRC_A 2
`define INSC_SRC_B 3
`define INSC_SRC_C 9
// reset values
`define INSC_RST_4 4'h0
`define INSC_RST_10 10'h000
// wake wait lengths in mclk cycles (2^20, 2^17, 2^15, 2^13)
`define INSC_WAIT20 1048576
`define INSC_WAIT17 131072
`define INSC_WAIT15 32768
`define INSC_WAIT13 8192
// instructions run after a wake before vectoring
`define INSC_WAKE_INSTR 2'h2
`endif

// *** verilog/insc_pkg.sv ***
// types of the nesting/standby controller
package insc_pkg;
  // standby state machine
  typedef enum logic [1:0] {
    SB_RUN = 2'b00,
    SB_HALT = 2'b01,
    SB_STOP = 2'b10,
    SB_WAIT = 2'b11
  } insc_sb_t;
  // instruction strobes from the sequencer
  typedef struct packed {
    logic ei;
    logic di;
    logic return_from_interrupt;
    logic stop;
    logic halt;
    logic take;
    logic instrDone;
  } insc_cpu_t;
  // clock selections of the peripheral units
  typedef struct packed {
    logic ser0Ext;
    logic ser1Ext;
    logic tmr0Pin;
    logic watchSub;
    logic mainOscOn;
    logic cpuOnSub;
  } insc_sel_t;
  // run enables handed to the units
  typedef struct packed {
    logic mainClk;
    logic cpuClk;
    logic bt;
    logic ser0;
    logic ser1;
    logic tmr0;
    logic watch;
    logic tpg;
    logic evc;
    logic adc;
  } insc_run_t;
endpackage

// *** verification/insc_cpu_model.sv ***
// cpu core model that takes vectors and returns from them
`timescale 1ns/1ps
`default_nettype none
module insc_cpu_model (
  input wire logic mclk, // system clock
  input wire logic srst, // sync reset, high
  input wire insc_pkg::insc_cpu_t cmd, // strobes asked by the bench
  input wire logic [1:0] lag, // stall cycles before a take
  input wire logic vecReq, // vector request
  input wire logic [1:0] pushNest, // status pushed at take
  input wire insc_pkg::insc_sb_t sbState, // standby state
  output insc_pkg::insc_cpu_t cpu, // strobes to the block
  output logic [1:0] restoreNest // status popped on return
);
  import insc_pkg::*;
  logic [1:0] stack[$]; // saved status, last in first out
  logic [1:0] stall; // stall counter, makes slow takes
  logic [1:0] due; // take sent, pushed status not settled yet
  logic beat; // paces instruction ends
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge mclk) begin
    cpu <= cmd;
    due <= {due[0], 1'b0};
    if (srst) begin
      stack.delete();
      stall <= 2'h0;
      due <= 2'h0;
      beat <= 1'b0;
      restoreNest <= 2'h0;
    end else begin
      beat <= ~beat;
      // a halted core ends no instruction
      cpu.instrDone <= beat && sbState == SB_RUN;
      if (vecReq && !cpu.take && due == 2'h0) begin
        stall <= stall + 2'h1;
        if (stall == lag) begin
          cpu.take <= 1'b1;
          stall <= 2'h0;
          due <= 2'h1;
        end
      end
      // pushed status settles one cycle after the take lands
      if (due[1])
        stack.push_back(pushNest);
      if (cmd.return_from_interrupt)
        restoreNest <= (stack.size() > 0) ? stack.pop_back() : 2'h0;
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench of the nesting and standby controller
`include "insc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import insc_pkg::*;
  localparam logic [6:0] OP_ENA = 7'h40; // enable strobe
  localparam logic [6:0] OP_DIS = 7'h20; // disable strobe
  localparam logic [6:0] OP_RET = 7'h10; // return strobe
  localparam logic [6:0] OP_STOP = 7'h08; // stop strobe
  localparam logic [6:0] OP_HALT = 7'h04; // halt strobe
  logic mclk = 1'b0; // clock
  logic srst = 1'b1; // reset
  logic [3:0] regAddr = 4'h0; // bus address
  logic [15:0] regWdata = 16'h0000; // bus data
  logic regWr = 1'b0; // write strobe
  logic regRd = 1'b0; // read strobe
  logic [15:0] regRdata; // read data
  insc_cpu_t cmd = '0; // strobes for the core model
  insc_cpu_t cpu; // strobes from the core model
  logic [1:0] restoreNest; // popped status
  logic [1:0] lag = 2'h0; // core stall
  logic [3:0] extPin = 4'h0; // external inputs
  logic btTick = 1'b0; // timer tick
  logic [4:0] unitEvent = 5'h00; // unit events
  insc_sel_t clkSel = 6'h02; // main oscillator on
  logic vecReq; // vector request
  logic [2:0] vecIdx; // vector number
  logic [1:0] pushNest; // pushed status
  logic resumeCpu; // wake pulse
  insc_run_t unitRun; // unit enables
  insc_sb_t sbState; // standby state
  int errTotal = 0; // mismatches
  int nTests = 0; // comparisons
  always #20 mclk = ~mclk;
  insc_ctrl #(.WAIT20(16), .WAIT17(12), .WAIT15(10), .WAIT13(8)) i_insc_ctrl (.mclk(mclk), .srst(srst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpu(cpu),
    .restoreNest(restoreNest), .extPin(extPin), .btTick(btTick), .unitEvent(unitEvent), .clkSel(clkSel),
    .vecReq(vecReq), .vecIdx(vecIdx), .pushNest(pushNest), .resumeCpu(resumeCpu), .unitRun(unitRun),
    .sbState(sbState));
  insc_cpu_model i_insc_cpu_model (.mclk(mclk), .srst(srst), .cmd(cmd), .lag(lag), .vecReq(vecReq),
    .pushNest(pushNest), .sbState(sbState), .cpu(cpu), .restoreNest(restoreNest));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nTests++;
    if (g !== e) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk(nm, e, regRdata);
  endtask
  task automatic op(input logic [6:0] c);
    @(posedge mclk);
    cmd <= insc_cpu_t'(c);
    @(posedge mclk);
    cmd <= '0;
  endtask
  // pins go through a synchroniser, so hold them several cycles
  task automatic pin(input logic [3:0] v);
    @(posedge mclk);
    extPin <= v;
    repeat (4) @(posedge mclk);
    extPin <= 4'h0;
  endtask
  task automatic ev(input logic [5:0] v);
    @(posedge mclk);
    {btTick, unitEvent} <= v;
    @(posedge mclk);
    {btTick, unitEvent} <= 6'h00;
  endtask
  function automatic logic probe(input int s);
    if (s == 0)
      return vecReq;
    return sbState == insc_sb_t'(s - 2);
  endfunction
  // bounded wait; the count of cycles comes back in n
  task automatic waitSig(input string nm, input int s, input int lim, output int n);
    n = 0;
    while (probe(s) !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        errTotal++;
        $display("wrong value %s expected 1 seen 0", nm);
        endOfTest();
      end
    end
  endtask
  task automatic waitVec(input logic [2:0] e);
    int n;
    lag <= 2'($urandom);
    waitSig("vecReq", 0, 40, n);
    chk("vecIdx", {13'h0, e}, {13'h0, vecIdx});
    while (vecReq === 1'b1 && n < 80) begin
      @(negedge mclk);
      n++;
    end
    chk("vecReq after take", 16'h0, {15'h0, vecReq});
  endtask
  task automatic noVec();
    int bad;
    bad = 0;
    repeat (12) begin
      @(negedge mclk);
      if (vecReq !== 1'b0)
        bad++;
    end
    chk("blocked vector", 16'h0, 16'(bad));
  endtask
  // unit enables expected in stop or halt
  function automatic logic [9:0] expRun(input logic stp, input insc_sel_t s);
    logic m;
    m = !stp && s.mainOscOn;
    return {m, 1'b0, !stp, m | s.ser0Ext, stp ? s.ser1Ext : m, stp ? s.tmr0Pin : 1'b1,
      stp ? s.watchSub : 1'b1, m, m, m};
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    int r;
    logic [9:0] en;
    r = $urandom(32'hA97731AD);
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++)
      rd(4'(a), 16'h0000, "reset value");
    chk("reset unitRun", 16'h03FF, {6'h00, unitRun});
    repeat (4) begin
      en = 10'($urandom);
      wr(`INSC_OFS_IEN, {6'h00, en});
      rd(`INSC_OFS_IEN, {6'h00, en}, "enable flags");
    end
    $display("test registers done");
    wr(`INSC_OFS_IEN, 16'h000C);
    wr(`INSC_OFS_PRIO, 16'h0002);
    op(OP_ENA);
    rd(`INSC_OFS_PRIO, 16'h000A, "priority reg");
    wr(`INSC_OFS_IRQ, 16'h0004);
    waitVec(3'h1);
    rd(`INSC_OFS_PSW, 16'h0004, "status one");
    chk("pushNest", 16'h0000, {14'h0, pushNest});
    wr(`INSC_OFS_IRQ, 16'h0004);
    noVec();
    wr(`INSC_OFS_IRQ, 16'h000C);
    waitVec(3'h2);
    rd(`INSC_OFS_PSW, 16'h0008, "status two");
    chk("pushNest", 16'h0001, {14'h0, pushNest});
    wr(`INSC_OFS_IRQ, 16'h000C);
    noVec();
    op(OP_DIS);
    wr(`INSC_OFS_PSW, 16'h0000);
    op(OP_ENA);
    waitVec(3'h2);
    wr(`INSC_OFS_IRQ, 16'h0000);
    op(OP_RET);
    rd(`INSC_OFS_PSW, 16'h0000, "return one");
    op(OP_RET);
    rd(`INSC_OFS_PSW, 16'h0004, "return two");
    op(OP_RET);
    $display("test nesting done");
    wr(`INSC_OFS_IEN, 16'h0001);
    ev(6'h20);
    waitVec(3'h0);
    rd(`INSC_OFS_IRQ, 16'h0000, "single shared flag");
    op(OP_RET);
    wr(`INSC_OFS_IEN, 16'h0003);
    pin(4'h8);
    waitVec(3'h0);
    rd(`INSC_OFS_IRQ, 16'h0002, "both shared flags");
    op(OP_DIS);
    wr(`INSC_OFS_IRQ, 16'h0000);
    op(OP_RET);
    wr(`INSC_OFS_IEN, 16'h01F0);
    op(OP_ENA);
    r = $urandom % 5;
    for (int i = 0; i < 5; i++) begin
      n = (i + r) % 5;
      ev(6'(1 << n));
      waitVec(3'(n + 3));
      op(OP_RET);
    end
    $display("test vectors done");
    op(OP_DIS);
    wr(`INSC_OFS_IEN, 16'h0010);
    op(OP_HALT);
    waitSig("halt entry", 3, 4, n);
    rd(`INSC_OFS_PCC, 16'h0004, "halt bit");
    chk("halt units", {6'h00, expRun(1'b0, clkSel)}, {6'h00, unitRun});
    ev(6'h20);
    pin(4'h1);
    chk("halt kept", 16'h0001, {14'h0, sbState});
    ev(6'h01);
    waitSig("halt wake", 2, 4, n);
    rd(`INSC_OFS_IRQ, 16'h0011, "held flags");
    wr(`INSC_OFS_IRQ, 16'h0000);
    $display("test halt done");
    clkSel <= 6'h03;
    op(OP_STOP);
    repeat (4) @(posedge mclk);
    chk("stop on subclock", 16'h0000, {14'h0, sbState});
    clkSel <= {4'($urandom), 2'b10};
    repeat (8) @(posedge mclk);
    wr(`INSC_OFS_IEN, 16'h0008);
    wr(`INSC_OFS_BTM, 16'h0007);
    op(OP_ENA);
    op(OP_STOP);
    waitSig("stop entry", 4, 4, n);
    rd(`INSC_OFS_PCC, 16'h0008, "stop bit");
    chk("stop units", {6'h00, expRun(1'b1, clkSel)}, {6'h00, unitRun});
    pin(4'h2);
    waitSig("stop wake", 5, 8, n);
    waitSig("stop resume", 2, 40, n);
    chk("stop wait", 16'h0001, {15'h0, n >= 6 && n <= 12});
    waitVec(3'h2);
    op(OP_RET);
    op(OP_DIS);
    wr(`INSC_OFS_IRQ, 16'h0008);
    op(OP_STOP);
    waitSig("pending stop", 5, 4, n);
    waitSig("pending resume", 2, 40, n);
    rd(`INSC_OFS_IRQ, 16'h0008, "flag held");
    chk("no vector", 16'h0000, {15'h0, vecReq});
    $display("test stop done");
    endOfTest();
  end
endmodule
`default_nettype wire
